/* usb_ep_tx_pkg.sv */
// Package with register map, field layout and encodings of the endpoint transmit control block.
package usb_ep_tx_pkg;
  localparam int addr_w = 8;
  localparam logic [7:0] off_dev_addr = 8'h00;
  localparam logic [7:0] off_ctrl = 8'h04;
  localparam logic [7:0] off_irq_status = 8'h08;
  localparam logic [7:0] off_irq_mask = 8'h0c;
  localparam logic [7:0] off_ep_base = 8'h10;
  localparam int ep_max = 3;
  localparam int status_out_bit = 7;
  localparam int tx_toggle_bit = 6;
  localparam int stat_hi = 5;
  localparam int stat_lo = 4;
  localparam int count_hi = 3;
  localparam int ctrl_force_bit = 0;
  localparam int ctrl_rxtog_bit = 1;
  localparam logic [1:0] ctrl_reset = 2'h0;
  localparam logic [7:0] dev_addr_reset = 8'h00;
  localparam logic [7:0] ep_reset = 8'h00;
  localparam logic [3:0] tbc_max = 4'h8;
  localparam int irq_w = 4;
  localparam int irq_xfer_done = 0;
  localparam int irq_bus_reset = 1;
  localparam int irq_stall = 2;
  localparam int irq_nak = 3;
  typedef enum logic [1:0] {
    stat_disabled = 2'b00,
    stat_stall = 2'b01,
    stat_nak = 2'b10,
    stat_valid = 2'b11
  } tx_stat_t;
  typedef enum logic [1:0] {
    hs_none = 2'b00,
    hs_ack = 2'b01,
    hs_nak = 2'b10,
    hs_stall = 2'b11
  } handshake_t;
endpackage

/* usb_ep_tx_ctrl.sv */
// Device address and per-endpoint transmit control with an APB register port.
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1 - Address register bit seven reads zero
// RULE2 - Seven-bit address matches bus transactions
// RULE3 - Software loads host-assigned enumeration address
// RULE4 - Address cleared by reset, bus reset, force
// RULE5 - Endpoint registers cleared by bus reset
// RULE6 - Status-out set stalls nonzero OUT data
// RULE7 - Status-out clear accepts any OUT length
// RULE8 - Toggle bit selects DATA0 or DATA1
// RULE9 - SETUP sets transmit toggle to one
// RULE10 - Toggle inverts only after host ACK
// RULE11 - Toggles updated by hardware or software
// RULE12 - Status field: disabled, stall, NAK, valid
// RULE13 - Correct IN/SETUP transfer sets status NAK
// RULE14 - Software writes byte count before sending
// RULE15 - Software never programs count above eight
// RULE16 - Endpoints zero, one; third is optional
// RULE17 - Valid IN sends count bytes, toggle PID
module usb_ep_tx_ctrl
  import usb_ep_tx_pkg::*;
#(
  parameter int num_ep = 3
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usb_ep_tx_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded token events from the serial engine, one-cycle pulses.
  input wire logic bus_reset,
  input wire logic tok_valid,
  input wire logic [6:0] tok_addr,
  input wire logic [1:0] tok_ep,
  input wire logic tok_in,
  input wire logic tok_out,
  input wire logic tok_setup,
  input wire logic out_nonzero,
  input wire logic host_ack,
  input wire logic xfer_done,
  // Answers to the serial engine.
  output logic [1:0] in_handshake,
  output logic in_send,
  output logic in_data1,
  output logic [3:0] in_count,
  output logic out_stall,
  output logic rx_toggle,
  output logic forced_bus_reset_bit,
  // Interrupt.
  output logic irq
);
  import usb_ep_tx_pkg::*;

  logic [6:0] usb_device_address_q;
  logic [7:0] ep_q [num_ep];
  logic [7:0] ep_d [num_ep];
  logic [1:0] ctrl_q;
  logic [irq_w-1:0] irq_status_q;
  logic [irq_w-1:0] irq_mask_q;
  logic [1:0] in_hs_q;
  logic in_send_q;
  logic in_data1_q;
  logic [3:0] in_count_q;
  logic out_stall_q;
  logic [1:0] last_ep_q;

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire hit_addr = paddr == off_dev_addr;
  wire hit_ctrl = paddr == off_ctrl;
  wire hit_stat = paddr == off_irq_status;
  wire hit_mask = paddr == off_irq_mask;
  // Endpoint registers sit four bytes apart above the base; anything past the last
  // endpoint falls through to the error response.
  wire [7:0] ep_off = paddr - off_ep_base;
  wire hit_ep = paddr >= off_ep_base && ep_off[1:0] == 2'b00 && ep_off[7:2] < num_ep;
  wire [1:0] ep_idx = ep_off[3:2];
  wire mapped = hit_addr || hit_ctrl || hit_stat || hit_mask || hit_ep;
  wire clear_all = bus_reset || ctrl_q[ctrl_force_bit]; // RULE4 RULE5
  // Tokens for other addresses or absent endpoints are ignored outright.
  wire addr_match = tok_valid && tok_addr == usb_device_address_q; // RULE2
  wire tok_ep_ok = {30'h0, tok_ep} < num_ep;
  wire [7:0] tok_reg = tok_ep_ok ? ep_q[tok_ep] : 8'h00;
  wire [1:0] tok_stat = tok_reg[stat_hi:stat_lo];
  wire ev_in = addr_match && tok_in && tok_ep_ok;
  wire ev_out = addr_match && tok_out && tok_ep_ok;
  wire stall_now = (ev_in && tok_stat == stat_stall) ||
                   (ev_out && tok_reg[status_out_bit] && out_nonzero);
  wire nak_now = ev_in && tok_stat == stat_nak;
  // Each event pulse becomes a sticky status bit below.
  wire [irq_w-1:0] irq_events = {nak_now, stall_now, bus_reset, xfer_done};

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign in_handshake = in_hs_q;
  assign in_send = in_send_q;
  assign in_data1 = in_data1_q;
  assign in_count = in_count_q;
  assign out_stall = out_stall_q;
  assign rx_toggle = ctrl_q[ctrl_rxtog_bit];
  assign forced_bus_reset_bit = ctrl_q[ctrl_force_bit];
  assign irq = |(irq_status_q & irq_mask_q);

  // Reads return zero outside the access phase, so a stale value can never be
  // mistaken for register contents.
  always_comb begin
    prdata = 32'h0;
    if (rd_en && hit_addr) begin
      prdata = {25'h0, usb_device_address_q}; // RULE1
    end else if (rd_en && hit_ctrl) begin
      prdata = {30'h0, ctrl_q};
    end else if (rd_en && hit_stat) begin
      prdata = {28'h0, irq_status_q};
    end else if (rd_en && hit_mask) begin
      prdata = {28'h0, irq_mask_q};
    end else if (rd_en && hit_ep) begin
      prdata = {24'h0, ep_q[ep_idx]};
    end
  end

  // Hardware events take precedence over a software write in the same cycle, so no
  // toggle or NAK update from the link is lost to a concurrent register write.
  always_comb begin
    for (int i = 0; i < num_ep; i++) begin
      ep_d[i] = ep_q[i];
      if (wr_en && hit_ep && ep_idx == 2'(i)) begin
        ep_d[i] = pwdata[7:0]; // RULE11 RULE14
      end
      if (addr_match && tok_ep == 2'(i)) begin
        if (tok_setup) begin
          ep_d[i][tx_toggle_bit] = 1'b1; // RULE9
        end
      end
      if (last_ep_q == 2'(i) && host_ack) begin
        ep_d[i][tx_toggle_bit] = ~ep_q[i][tx_toggle_bit]; // RULE10
      end
      if (last_ep_q == 2'(i) && xfer_done) begin
        ep_d[i][stat_hi:stat_lo] = stat_nak; // RULE13
      end
    end
  end

  // A bus reset or the forced reset bit wipes the whole register, count included, so
  // software must reload the count after every reset.
  for (genvar g = 0; g < num_ep; g++) begin : g_ep
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ep_q[g] <= ep_reset;
      end else if (clear_all) begin
        ep_q[g] <= ep_reset; // RULE5 RULE16
      end else begin
        ep_q[g] <= ep_d[g];
      end
    end
  end

  // Bit seven is never stored, so it reads zero whatever software writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_device_address_q <= dev_addr_reset[6:0];
    end else if (clear_all) begin
      usb_device_address_q <= dev_addr_reset[6:0]; // RULE4
    end else if (wr_en && hit_addr) begin
      usb_device_address_q <= pwdata[6:0]; // RULE2 RULE3
    end
  end

  // The forced reset bit stays set until software clears it, holding the address and
  // the endpoints cleared for as long as it does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ctrl_reset;
    end else if (wr_en && hit_ctrl) begin
      ctrl_q <= pwdata[1:0]; // RULE11
    end else if (bus_reset) begin
      ctrl_q[ctrl_rxtog_bit] <= 1'b0;
    end
  end

  // Write-one-to-clear status; a new event in the same cycle keeps its bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~((wr_en && hit_stat) ? pwdata[irq_w-1:0] : '0))
                      | irq_events;
      if (wr_en && hit_mask) begin
        irq_mask_q <= pwdata[irq_w-1:0];
      end
    end
  end

  // Answer to each token, registered one cycle after the token.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_hs_q <= hs_none;
      in_send_q <= 1'b0;
      in_data1_q <= 1'b0;
      in_count_q <= 4'h0;
      out_stall_q <= 1'b0;
      last_ep_q <= 2'b00;
    end else begin
      in_hs_q <= hs_none;
      in_send_q <= 1'b0;
      out_stall_q <= ev_out && tok_reg[status_out_bit] && out_nonzero; // RULE6 RULE7
      if (addr_match && tok_ep_ok && (tok_in || tok_setup)) begin
        last_ep_q <= tok_ep;
      end
      if (ev_in) begin
        unique case (tok_stat)
          stat_disabled: in_hs_q <= hs_none; // RULE12
          stat_stall: in_hs_q <= hs_stall;
          stat_nak: in_hs_q <= hs_nak;
          stat_valid: begin
            // Toggle and count are latched only here so they hold for the whole packet.
            in_send_q <= 1'b1; // RULE17
            in_data1_q <= tok_reg[tx_toggle_bit]; // RULE8
            in_count_q <= tok_reg[count_hi:0];
          end
        endcase
      end
    end
  end

  // Register port: reads, writes and what they leave alone.
  addr_bit7_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    rd_en && hit_addr |-> prdata[7] == 1'b0) else $error("address bit 7 not zero");

  addr_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    rd_en && hit_addr |-> prdata[6:0] == usb_device_address_q)
    else $error("address read mismatch");

  addr_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2 RULE3
    wr_en && hit_addr && !clear_all |=> usb_device_address_q == $past(pwdata[6:0]))
    else $error("address write lost");

  addr_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    !clear_all && !(wr_en && hit_addr) |=> $stable(usb_device_address_q))
    else $error("address changed unasked");

  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    wr_en && hit_ctrl |=> ctrl_q == $past(pwdata[1:0])) else $error("control write lost");

  ep_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11 RULE14
    wr_en && hit_ep && ep_idx == 2'd1 && !clear_all && !(addr_match && tok_ep == 2'd1)
    && !(last_ep_q == 2'd1 && (host_ack || xfer_done))
    |=> ep_q[1] == $past(pwdata[7:0])) else $error("endpoint write lost");

  // Every reset source clears the address and the endpoints.
  addr_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    clear_all |=> usb_device_address_q == 7'h0) else $error("address not cleared");

  ep_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    bus_reset |=> ep_q[0] == ep_reset) else $error("endpoint not cleared");

  ep_force_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4 RULE5
    ctrl_q[ctrl_force_bit] |=> ep_q[1] == ep_reset)
    else $error("forced reset missed endpoint");

  ep_top_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5 RULE16
    bus_reset |=> ep_q[num_ep-1][7:4] == 4'h0)
    else $error("last endpoint not cleared");

  rx_tog_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    bus_reset && !(wr_en && hit_ctrl) |=> !rx_toggle)
    else $error("receive toggle kept");

  // OUT answers.
  out_stall_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    ev_out && out_nonzero && tok_reg[status_out_bit] && !clear_all |=> out_stall)
    else $error("OUT not stalled");

  out_accept_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    ev_out && !tok_reg[status_out_bit] |=> !out_stall) else $error("OUT stalled wrongly");

  out_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6 RULE7
    ev_out && !out_nonzero |=> !out_stall) else $error("empty OUT stalled");

  out_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    !ev_out |=> !out_stall) else $error("stall without OUT token");

  foreign_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    tok_valid && tok_addr != usb_device_address_q
    |=> !in_send && !out_stall && in_handshake == hs_none) else $error("foreign token answered");

  // Toggle and status updates on endpoint 0; the SETUP toggle is also checked on endpoint 1.
  setup_tog_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    addr_match && tok_setup && tok_ep == 2'd0 && !clear_all && !(host_ack && last_ep_q == 2'd0)
    |=> ep_q[0][tx_toggle_bit]) else $error("SETUP did not set toggle");

  setup_tog1_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    addr_match && tok_setup && tok_ep == 2'd1 && !clear_all && !(host_ack && last_ep_q == 2'd1)
    |=> ep_q[1][tx_toggle_bit]) else $error("SETUP did not set toggle");

  tog_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    !host_ack && !tok_setup && !clear_all && !(wr_en && hit_ep)
    |=> $stable(ep_q[0][tx_toggle_bit])) else $error("toggle changed without ACK");

  ack_flip_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    host_ack && last_ep_q == 2'd0 && !clear_all
    |=> ep_q[0][tx_toggle_bit] != $past(ep_q[0][tx_toggle_bit])) else $error("ACK kept toggle");

  xfer_nak_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    xfer_done && last_ep_q == 2'd0 && !clear_all |=> ep_q[0][stat_hi:stat_lo] == stat_nak)
    else $error("status not NAK after transfer");

  // IN answers.
  in_pid_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8 RULE17
    ev_in && tok_stat == stat_valid |=> in_send && in_data1 == $past(tok_reg[tx_toggle_bit])
    && in_count == $past(tok_reg[count_hi:0])) else $error("IN answer wrong");

  in_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    !ev_in |=> $stable(in_data1) && $stable(in_count)) else $error("IN data changed idle");

  in_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12 RULE17
    !ev_in |=> !in_send && in_handshake == hs_none) else $error("answer without IN token");

  in_stall_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    ev_in && tok_stat == stat_stall |=> in_handshake == hs_stall) else $error("IN not stalled");

  in_nak_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    ev_in && tok_stat == stat_nak |=> in_handshake == hs_nak) else $error("IN not NAKed");

  in_disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    ev_in && tok_stat == stat_disabled |=> in_handshake == hs_none && !in_send)
    else $error("disabled endpoint answered");

  in_valid_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12 RULE17
    ev_in && tok_stat == stat_valid |=> in_handshake == hs_none) else $error("handshake with data");

  stall_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    stall_now |=> irq_status_q[irq_stall]) else $error("stall event not flagged");

  nak_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    nak_now |=> irq_status_q[irq_nak]) else $error("NAK event not flagged");
endmodule
`default_nettype wire

/* usb_host_model.sv */
// Host-side model that issues decoded tokens and handshakes to the block.
`timescale 1ns/1ns
`default_nettype none
module usb_host_model (
  // Clock.
  input wire logic pclk,
  // Token events.
  output logic bus_reset,
  output logic tok_valid,
  output logic [6:0] tok_addr,
  output logic [1:0] tok_ep,
  output logic tok_in,
  output logic tok_out,
  output logic tok_setup,
  output logic out_nonzero,
  // Host handshakes.
  output logic host_ack,
  output logic xfer_done
);
  initial begin
    {bus_reset, tok_valid, tok_addr, tok_ep, tok_in, tok_out, tok_setup} = '0;
    {out_nonzero, host_ack, xfer_done} = '0;
  end
  // Kind 0 is IN, 1 is OUT, 2 is SETUP; each token stands one cycle.
  task automatic token(input int kind, input logic [1:0] ep, input logic [6:0] a,
                       input logic nz);
    @(posedge pclk);
    tok_valid <= 1'b1;
    tok_in <= (kind == 0);
    tok_out <= (kind == 1);
    tok_setup <= (kind == 2);
    tok_ep <= ep;
    tok_addr <= a;
    out_nonzero <= nz;
    @(posedge pclk);
    tok_valid <= 1'b0;
    {tok_in, tok_out, tok_setup} <= 3'h0;
    // Released lines flip so a stale address can never pass for a live one.
    tok_addr <= ~a;
    tok_ep <= ~ep;
    out_nonzero <= ~nz;
  endtask
  // Event 0 is an ACK, 1 a correct transfer, 2 a bus reset.
  task automatic pulse(input int ev);
    @(posedge pclk);
    host_ack <= (ev == 0);
    xfer_done <= (ev == 1);
    bus_reset <= (ev == 2);
    @(posedge pclk);
    {host_ack, xfer_done, bus_reset} <= 3'h0;
  endtask
endmodule
`default_nettype wire

/* usb_endpoint_tx_control_tb.sv */
// Self-checking testbench of the endpoint transmit control block.
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_tx_control_tb;
  import usb_ep_tx_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, bus_reset, tok_valid, tok_in, tok_out, tok_setup;
  logic out_nonzero, host_ack, xfer_done, in_send, in_data1, out_stall, rx_toggle;
  logic forced_bus_reset_bit, irq;
  logic [6:0] tok_addr;
  logic [1:0] tok_ep, in_handshake;
  logic [3:0] in_count;
  int errors = 0;
  int checks = 0;
  always #50 pclk = ~pclk;
  usb_host_model u_host (.pclk, .bus_reset, .tok_valid, .tok_addr, .tok_ep, .tok_in,
    .tok_out, .tok_setup, .out_nonzero, .host_ack, .xfer_done);
  usb_ep_tx_ctrl #(.num_ep(3)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bus_reset, .tok_valid, .tok_addr, .tok_ep,
    .tok_in, .tok_out, .tok_setup, .out_nonzero, .host_ack, .xfer_done, .in_handshake,
    .in_send, .in_data1, .in_count, .out_stall, .rx_toggle, .forced_bus_reset_bit, .irq);
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_address;
    rchk(off_ep_base, 32'h0);
    apb(1'b1, off_dev_addr, 32'hff);
    rchk(off_dev_addr, 32'h7f);
    u_host.token(0, 2'h0, 7'h12, 1'b0);
    #1 chk(in_send, 1'b0);
  endtask
  task automatic t_in_path;
    logic [1:0] hs [3] = '{hs_none, hs_stall, hs_nak};
    apb(1'b1, off_ep_base, 32'h35);
    u_host.token(0, 2'h0, 7'h12, 1'b0);
    #1 chk(in_send, 1'b0);
    u_host.token(0, 2'h0, 7'h7f, 1'b0);
    #1 chk({in_send, in_data1, in_count}, 6'h25);
    u_host.pulse(0);
    rchk(off_ep_base, 32'h75);
    u_host.token(0, 2'h0, 7'h7f, 1'b0);
    #1 chk(in_data1, 1'b1);
    rchk(off_ep_base, 32'h75);
    u_host.pulse(1);
    rchk(off_ep_base, 32'h65);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, off_ep_base, {26'h0, s[1:0], 4'h5});
      u_host.token(0, 2'h0, 7'h7f, 1'b0);
      #1 chk(in_handshake, hs[s]);
    end
  endtask
  task automatic t_setup_out;
    apb(1'b1, 8'h14, 32'h0);
    u_host.token(2, 2'h1, 7'h7f, 1'b0);
    rchk(8'h14, 32'h40);
    apb(1'b1, 8'h14, 32'h88);
    u_host.token(1, 2'h1, 7'h7f, 1'b1);
    #1 chk(out_stall, 1'b1);
    u_host.token(1, 2'h1, 7'h7f, 1'b0);
    #1 chk(out_stall, 1'b0);
    apb(1'b1, 8'h14, 32'h08);
    u_host.token(1, 2'h1, 7'h7f, 1'b1);
    #1 chk(out_stall, 1'b0);
    apb(1'b1, 8'h18, 32'h3f);
    rchk(8'h18, 32'h3f);
  endtask
  task automatic t_resets;
    u_host.pulse(2);
    rchk(off_dev_addr, 32'h0);
    rchk(8'h14, 32'h0);
    apb(1'b1, off_dev_addr, 32'h2a);
    apb(1'b1, off_ctrl, 32'h1);
    rchk(off_dev_addr, 32'h0);
    chk(forced_bus_reset_bit, 1'b1);
    apb(1'b1, off_ctrl, 32'h2);
    #1 chk(rx_toggle, 1'b1);
    u_host.pulse(2);
    #1 chk(rx_toggle, 1'b0);
    apb(1'b1, off_ctrl, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
  endtask
  task automatic t_irq;
    apb(1'b1, off_irq_mask, 32'h2);
    repeat (2) @(posedge pclk);
    #1 chk(irq, 1'b1);
    apb(1'b1, off_irq_status, 32'h2);
    repeat (2) @(posedge pclk);
    #1 chk(irq, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_address();
    t_in_path();
    t_setup_out();
    t_resets();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
